//--- include/alm_pkg.sv
// Shared constants and types of the address-load, lock and mmap decoder
// Assumes one core clock and a synchronous active-high reset
`default_nettype none
package alm_pkg;
  localparam int PW = 23; // Extended pointer width
  localparam logic [7:0] OP_XLOAD = 8'hEC; // Six-byte extended immediate load
  localparam logic [7:0] OP_ST_K8 = 8'hE6; // Store of 8-bit signed constant
  localparam logic [7:0] OP_ST_K16 = 8'hFB; // Store of 16-bit signed constant
  localparam logic [7:0] OP_MAR = 8'hB4; // Register modify, no memory access
  localparam logic [7:0] OP_RMW_FIRST = 8'hD0; // First lockable code
  localparam logic [7:0] OP_RMW_LAST = 8'hDC; // Last of thirteen lockable codes
  localparam logic [7:0] QUAL_MMAP = 8'h98; // One-byte register-map qualifier
  localparam logic [15:0] QUAL_LOCK = 16'h45F2; // Two-byte lock qualifier
  localparam logic [PW-1:0] MMAP_BASE = 23'h000000; // Mapped page start
  localparam logic [6:0] MMR_LAST = 7'h5F; // Highest mapped register word
  localparam logic [PW-1:0] PTR_RST = 23'h000000; // Pointer value after reset
  localparam logic [3:0] DST_SP = 4'h8; // Extended stack pointer
  localparam logic [3:0] DST_SSP = 4'h9; // Extended system stack pointer
  localparam logic [3:0] DST_DP = 4'hA; // Extended data page
  localparam logic [3:0] DST_CDP = 4'hB; // Extended coefficient pointer
  // Indirect addressing modes in operand bits 3:1
  typedef enum logic [2:0] {
    AM_PLAIN = 3'h0, AM_POST_INC = 3'h1, AM_POST_DEC = 3'h2, AM_PRE_INC = 3'h3,
    AM_PRE_DEC = 3'h4, AM_REG_OFS = 3'h5, AM_POST_ADD = 3'h6, AM_PORT = 3'h7
  } alm_amode_t;
  // Lockable operations, code minus first code
  typedef enum logic [3:0] {
    RMW_TSET_F1 = 4'h0, RMW_TSET_F2 = 4'h1, RMW_TCLR_F1 = 4'h2,
    RMW_TCLR_F2 = 4'h3, RMW_TNOT_F1 = 4'h4, RMW_TNOT_F2 = 4'h5,
    RMW_BSET = 4'h6, RMW_BCLR = 4'h7, RMW_BNOT = 4'h8, RMW_AND = 4'h9,
    RMW_OR = 4'hA, RMW_XOR = 4'hB, RMW_ADD = 4'hC
  } alm_rmw_t;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_RD = 4'h2, ST_RWAIT = 4'h4, ST_WR = 4'h8
  } alm_state_t;
  // Circular wrap of the low 16 bits inside a buffer of given size
  function automatic logic [PW-1:0] circ_fix(input logic [PW-1:0] old_v,
      input logic [PW-1:0] new_v, input logic [15:0] size, input logic down);
    logic [PW-1:0] r;
    r = new_v;
    if (size != 16'h0000) begin
      r[PW-1:16] = old_v[PW-1:16];
      if (down && old_v[15:0] == 16'h0000) begin
        r[15:0] = size - 16'h0001;
      end else if (!down && new_v[15:0] >= size) begin
        r[15:0] = new_v[15:0] - size;
      end
    end
    return r;
  endfunction : circ_fix
endpackage : alm_pkg
`default_nettype wire

//--- verilog/alm_agen.sv
// Address generator: operand address and pointer update for one operand
// Assumes pointer values and sizes are stable while the packet is offered
`timescale 1ns/1ps
`default_nettype none
module alm_agen (
  input wire logic [7:0] smem,
  input wire logic [alm_pkg::PW-1:0] ar_val,
  input wire logic [alm_pkg::PW-1:0] dp_val,
  input wire logic [alm_pkg::PW-1:0] sp_val,
  input wire logic stack_rel,
  input wire logic mmap,
  input wire logic [15:0] ofs,
  input wire logic circ_en,
  input wire logic [15:0] size,
  output logic [alm_pkg::PW-1:0] ea,
  output logic [alm_pkg::PW-1:0] ar_nxt,
  output logic ar_upd
);
  logic [alm_pkg::PW-1:0] raw; // Unwrapped pointer update
  logic down; // Update steps downward
  logic pre; // Address uses updated pointer
  alm_pkg::alm_amode_t mode; // Decoded indirect mode

  // Address and pointer arithmetic
  always_comb begin
    mode = alm_pkg::alm_amode_t'(smem[3:1]);
    raw = ar_val;
    down = 1'b0;
    pre = 1'b0;
    ar_upd = 1'b0;
    ea = ar_val;
    if (!smem[0]) begin
      // Direct: page base plus 7-bit offset; mapped page when forced
      ea = (mmap ? alm_pkg::MMAP_BASE : (stack_rel ? sp_val : dp_val)) + {16'h0000, smem[7:1]};
    end else begin
      case (mode)
        alm_pkg::AM_POST_INC: begin raw = ar_val + 23'h000001; ar_upd = 1'b1; end
        alm_pkg::AM_POST_DEC: begin raw = ar_val - 23'h000001; ar_upd = 1'b1; down = 1'b1; end
        alm_pkg::AM_PRE_INC: begin raw = ar_val + 23'h000001; ar_upd = 1'b1; pre = 1'b1; end
        alm_pkg::AM_PRE_DEC: begin
          raw = ar_val - 23'h000001;
          ar_upd = 1'b1;
          down = 1'b1;
          pre = 1'b1;
        end
        alm_pkg::AM_REG_OFS: ea = ar_val + {7'h00, ofs};
        alm_pkg::AM_POST_ADD: begin raw = ar_val + {7'h00, ofs}; ar_upd = 1'b1; end
        default: ea = ar_val;
      endcase
    end
    // Circular buffer shapes the stored pointer when enabled
    ar_nxt = circ_en ? alm_pkg::circ_fix(ar_val, raw, size, down) : raw;
    if (pre) begin
      ea = ar_nxt;
    end
  end
endmodule : alm_agen
`default_nettype wire

//--- verilog/alm_rmw_alu.sv
// Modify step of the thirteen read-modify-write operations
// Assumes the read word and the operand are valid in the cycle the read data returns
`timescale 1ns/1ps
`default_nettype none
module alm_rmw_alu (
  input wire logic [3:0] op,
  input wire logic [15:0] rdata,
  input wire logic [15:0] k,
  output logic [15:0] res,
  output logic tbit
);
  logic [15:0] mask; // One-hot bit selected by the low operand nibble

  // Bit and word operations
  always_comb begin
    mask = 16'h0001 << k[3:0];
    tbit = |(rdata & mask);
    case (alm_pkg::alm_rmw_t'(op))
      alm_pkg::RMW_TSET_F1, alm_pkg::RMW_TSET_F2, alm_pkg::RMW_BSET: res = rdata | mask;
      alm_pkg::RMW_TCLR_F1, alm_pkg::RMW_TCLR_F2, alm_pkg::RMW_BCLR: res = rdata & ~mask;
      alm_pkg::RMW_TNOT_F1, alm_pkg::RMW_TNOT_F2, alm_pkg::RMW_BNOT: res = rdata ^ mask;
      alm_pkg::RMW_AND: res = rdata & k;
      alm_pkg::RMW_OR: res = rdata | k;
      alm_pkg::RMW_XOR: res = rdata ^ k;
      alm_pkg::RMW_ADD: res = rdata + k;
      default: res = rdata;
    endcase
  end
endmodule : alm_rmw_alu
`default_nettype wire

//--- verilog/alm_decoder.sv
// Decoder and executor: extended immediate load, immediate store,
// lock and register-map qualifiers, pointer modify without access.
// Assumes one packet per handshake and a memory port that accepts
// one request at a time and returns read data a cycle or more later.
//
// Functional notes
// - Six-byte load writes zero-extended 23-bit constant
// - Extended load finishes in address stage, no memory
// - Extended load rejects pointer modify and port forms
// - Circular enable bit shapes extended load value
// - Immediate store writes constant through own datapath
// - 8-bit store constant sign-extended to 16 bits
// - Lock qualifier pairs only with lockable operation
// - Lock with read; write next; others stalled
// - Lock alone, misplaced or extra-parallel is illegal
// - Thirteen bit-test, bit and word lockable operations
// - Register-map qualifier forces direct base zero
// - Register-map needs memory operand, no byte moves
// - Mapped words 0h-5Fh; scratch-pad unreachable
// - Register-map packet takes no extra parallel instruction
// - Pointer modify applied in address stage, no access
// - Circular enable bit shapes modified pointer
// - Legacy mode uses first size register only
`timescale 1ns/1ps
`default_nettype none
module alm_decoder #(
  parameter int NUM_AUX = 8 // Extended auxiliary pointers
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PKT_VALID,
  output logic PKT_READY,
  input wire logic [47:0] PKT_BYTES,
  input wire logic [1:0] QUAL_LEN,
  input wire logic [15:0] QUAL_BYTES,
  input wire logic PAR_EXTRA,
  input wire logic COND_D_EXEC,
  input wire logic [15:0] STATUS_WORD_TWO,
  input wire logic LEGACY_COMPAT_MODE,
  input wire logic [15:0] CIRC_SIZE_REG_FIRST,
  input wire logic [15:0] CIRC_SIZE_REG_SECOND,
  input wire logic [15:0] OFFSET_REG,
  input wire logic STACK_REL_MODE,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [alm_pkg::PW-1:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic MEM_LOCK,
  input wire logic MEM_ACCEPT,
  input wire logic MEM_RVALID,
  input wire logic [15:0] MEM_RDATA,
  output logic OTHER_REQ_STALL,
  output logic PTR_WR_VALID,
  output logic [3:0] PTR_WR_SEL,
  output logic [alm_pkg::PW-1:0] PTR_WR_DATA,
  output logic TEST_FLAG_ONE,
  output logic TEST_FLAG_TWO,
  output logic ILLEGAL_PKT,
  output logic PKT_DONE
);
  localparam int PW = alm_pkg::PW;

  // Refuse pointer counts the 3-bit register field cannot serve
  if (NUM_AUX != 8) begin : g_chk
    $error("NUM_AUX must be 8");
  end

  // All block state
  typedef struct packed {
    alm_pkg::alm_state_t st; // Sequencer state
    logic [NUM_AUX-1:0][PW-1:0] aux; // Extended auxiliary pointers
    logic [PW-1:0] sp; // Extended stack pointer
    logic [PW-1:0] ssp; // Extended system stack pointer
    logic [PW-1:0] dp; // Extended data page
    logic [PW-1:0] cdp; // Extended coefficient pointer
    logic req; // Memory request
    logic we; // Request is a write
    logic [PW-1:0] addr; // Request address
    logic [15:0] wdata; // Write data
    logic lock; // Lock beside read request
    logic locked; // Locked pair in flight
    logic [3:0] rmw_op; // Pending modify operation
    logic [15:0] rmw_k; // Bit index or 16-bit constant
    logic tf1; // Test flag one
    logic tf2; // Test flag two
    logic illegal; // Packet rejected pulse
    logic done; // Packet finished pulse
    logic pw_valid; // Pointer write report
    logic [3:0] pw_sel; // Pointer written
    logic [PW-1:0] pw_data; // Value written
  } alm_regs_t;

  alm_regs_t s_ff; // Current state
  alm_regs_t nxt_s; // Next state

  logic acc; // Packet taken this cycle
  logic [7:0] op; // Main opcode byte
  logic [7:0] smem; // Operand byte
  logic [2:0] arn; // Pointer named by operand
  logic [3:0] dst; // Extended load destination
  logic [PW-1:0] k23; // Extended load constant
  logic [PW-1:0] x_raw; // Constant plus register offset
  logic [PW-1:0] x_val; // Value written by extended load
  logic is_x, is_k8, is_k16, is_mar, is_rmw; // Opcode classes
  logic is_lock, is_mmap, bad_qual; // Qualifier classes
  logic lock_bad, mmap_bad, x_bad, illegal; // Pairing faults
  logic [PW-1:0] ea; // Operand address
  logic [PW-1:0] ar_nxt; // Updated pointer
  logic ar_upd; // Operand modifies its pointer
  logic [15:0] alu_res; // Modified word
  logic alu_bit; // Tested bit
  alm_pkg::alm_amode_t mode; // Indirect mode of operand

  // Circular size for a pointer; legacy mode uses the first one
  function automatic logic [15:0] pick_size(input logic [2:0] n);
    return (LEGACY_COMPAT_MODE || !n[2]) ? CIRC_SIZE_REG_FIRST : CIRC_SIZE_REG_SECOND;
  endfunction : pick_size

  // Packet fields and pairing checks
  always_comb begin
    op = PKT_BYTES[47:40];
    smem = PKT_BYTES[39:32];
    arn = smem[7:5];
    mode = alm_pkg::alm_amode_t'(smem[3:1]);
    dst = PKT_BYTES[7:4];
    k23 = {PKT_BYTES[30:24], PKT_BYTES[23:16], PKT_BYTES[15:8]};
    is_x = op == alm_pkg::OP_XLOAD;
    is_k8 = op == alm_pkg::OP_ST_K8;
    is_k16 = op == alm_pkg::OP_ST_K16;
    is_mar = op == alm_pkg::OP_MAR;
    is_rmw = op >= alm_pkg::OP_RMW_FIRST && op <= alm_pkg::OP_RMW_LAST;
    is_lock = QUAL_LEN == 2'h2 && QUAL_BYTES == alm_pkg::QUAL_LOCK;
    is_mmap = QUAL_LEN == 2'h1 && QUAL_BYTES[7:0] == alm_pkg::QUAL_MMAP;
    bad_qual = QUAL_LEN != 2'h0 && !is_lock && !is_mmap;
    // Lock only with a lockable op, alone in its packet
    lock_bad = is_lock && (!is_rmw || PAR_EXTRA || COND_D_EXEC);
    // Map needs a direct memory operand below the scratch-pad
    mmap_bad = is_mmap && (!(is_k8 || is_k16 || is_rmw) || smem[0]
      || smem[7:1] > alm_pkg::MMR_LAST || PAR_EXTRA);
    // Extended load: only plain or register-offset indirect forms
    x_bad = is_x && (dst > alm_pkg::DST_CDP
      || (smem[0] && mode != alm_pkg::AM_PLAIN && mode != alm_pkg::AM_REG_OFS));
    illegal = !(is_x || is_k8 || is_k16 || is_mar || is_rmw)
      || bad_qual || lock_bad || mmap_bad || x_bad;
    x_raw = k23;
    if (smem[0] && mode == alm_pkg::AM_REG_OFS) begin
      x_raw = k23 + {7'h00, OFFSET_REG};
    end
    x_val = x_raw;
    if (!dst[3] && STATUS_WORD_TWO[dst[2:0]]) begin
      x_val = alm_pkg::circ_fix(x_raw, x_raw, pick_size(dst[2:0]), 1'b0);
    end
  end

  // Operand address and pointer update
  alm_agen u_agen (
    .smem(smem),
    .ar_val(s_ff.aux[arn]),
    .dp_val(s_ff.dp),
    .sp_val(s_ff.sp),
    .stack_rel(STACK_REL_MODE),
    .mmap(is_mmap),
    .ofs(OFFSET_REG),
    .circ_en(STATUS_WORD_TWO[arn]),
    .size(pick_size(arn)),
    .ea(ea),
    .ar_nxt(ar_nxt),
    .ar_upd(ar_upd)
  );

  // Modify step of locked and unlocked read-modify-write
  alm_rmw_alu u_alu (
    .op(s_ff.rmw_op),
    .rdata(MEM_RDATA),
    .k(s_ff.rmw_k),
    .res(alu_res),
    .tbit(alu_bit)
  );

  // Packets are taken only while idle
  always_comb begin
    PKT_READY = s_ff.st == alm_pkg::ST_IDLE;
    acc = PKT_VALID && PKT_READY;
  end

  // Sequencer and pointer file
  always_comb begin
    nxt_s = s_ff;
    nxt_s.illegal = 1'b0;
    nxt_s.done = 1'b0;
    nxt_s.pw_valid = 1'b0;
    case (s_ff.st)
      alm_pkg::ST_IDLE: begin
        if (acc && illegal) begin
          nxt_s.illegal = 1'b1;
        end else if (acc) begin
          // Operand pointer update for all classes but extended load
          if (ar_upd && !is_x) begin
            nxt_s.aux[arn] = ar_nxt;
            nxt_s.pw_valid = 1'b1;
            nxt_s.pw_sel = {1'b0, arn};
            nxt_s.pw_data = ar_nxt;
          end
          if (is_x) begin
            // Address-stage write, no memory request
            nxt_s.pw_valid = 1'b1;
            nxt_s.pw_sel = dst;
            nxt_s.pw_data = x_val;
            case (dst)
              alm_pkg::DST_SP: nxt_s.sp = x_val;
              alm_pkg::DST_SSP: nxt_s.ssp = x_val;
              alm_pkg::DST_DP: nxt_s.dp = x_val;
              alm_pkg::DST_CDP: nxt_s.cdp = x_val;
              default: nxt_s.aux[dst[2:0]] = x_val;
            endcase
            nxt_s.done = 1'b1;
          end else if (is_mar) begin
            nxt_s.done = 1'b1;
          end else if (is_k8 || is_k16) begin
            nxt_s.req = 1'b1;
            nxt_s.we = 1'b1;
            nxt_s.addr = ea;
            nxt_s.wdata = is_k8 ? {{8{PKT_BYTES[31]}}, PKT_BYTES[31:24]} : PKT_BYTES[31:16];
            nxt_s.st = alm_pkg::ST_WR;
          end else begin
            // Read first; lock rides with the read
            nxt_s.req = 1'b1;
            nxt_s.we = 1'b0;
            nxt_s.addr = ea;
            nxt_s.lock = is_lock;
            nxt_s.locked = is_lock;
            nxt_s.rmw_op = 4'(op - alm_pkg::OP_RMW_FIRST);
            if (op >= 8'hD9) begin
              nxt_s.rmw_k = PKT_BYTES[31:16];
            end else if (op >= 8'hD6) begin
              nxt_s.rmw_k = {12'h000, OFFSET_REG[3:0]};
            end else begin
              nxt_s.rmw_k = {12'h000, PKT_BYTES[27:24]};
            end
            nxt_s.st = alm_pkg::ST_RD;
          end
        end
      end
      alm_pkg::ST_RD: begin
        if (MEM_ACCEPT) begin
          nxt_s.req = 1'b0;
          nxt_s.lock = 1'b0;
          nxt_s.st = alm_pkg::ST_RWAIT;
        end
      end
      alm_pkg::ST_RWAIT: begin
        // Matching write issued straight after the read data
        if (MEM_RVALID) begin
          nxt_s.req = 1'b1;
          nxt_s.we = 1'b1;
          nxt_s.wdata = alu_res;
          if (s_ff.rmw_op < 4'h6) begin
            if (s_ff.rmw_op[0]) begin
              nxt_s.tf2 = alu_bit;
            end else begin
              nxt_s.tf1 = alu_bit;
            end
          end
          nxt_s.st = alm_pkg::ST_WR;
        end
      end
      alm_pkg::ST_WR: begin
        if (MEM_ACCEPT) begin
          nxt_s.req = 1'b0;
          nxt_s.we = 1'b0;
          nxt_s.locked = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.st = alm_pkg::ST_IDLE;
        end
      end
      default: nxt_s.st = alm_pkg::ST_IDLE;
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      s_ff <= '0;
      s_ff.st <= alm_pkg::ST_IDLE;
      s_ff.aux <= {NUM_AUX{alm_pkg::PTR_RST}};
      s_ff.sp <= alm_pkg::PTR_RST;
      s_ff.ssp <= alm_pkg::PTR_RST;
      s_ff.dp <= alm_pkg::PTR_RST;
      s_ff.cdp <= alm_pkg::PTR_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  always_comb begin
    MEM_REQ = s_ff.req;
    MEM_WE = s_ff.we;
    MEM_ADDR = s_ff.addr;
    MEM_WDATA = s_ff.wdata;
    MEM_LOCK = s_ff.lock;
    OTHER_REQ_STALL = s_ff.locked;
    PTR_WR_VALID = s_ff.pw_valid;
    PTR_WR_SEL = s_ff.pw_sel;
    PTR_WR_DATA = s_ff.pw_data;
    TEST_FLAG_ONE = s_ff.tf1;
    TEST_FLAG_TWO = s_ff.tf2;
    ILLEGAL_PKT = s_ff.illegal;
    PKT_DONE = s_ff.done;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  a_lock_on_read: assert property (
    MEM_LOCK |-> MEM_REQ && !MEM_WE && OTHER_REQ_STALL)
    else $error("lock without a read request");
  a_lock_held_write: assert property (
    MEM_REQ && MEM_WE && OTHER_REQ_STALL && MEM_ACCEPT |=> !OTHER_REQ_STALL && PKT_DONE)
    else $error("stall not released after locked write");
  a_xload_no_mem: assert property (
    acc && is_x && !illegal |=> !MEM_REQ && PTR_WR_VALID && PKT_DONE)
    else $error("extended load touched memory");
  a_xload_zext: assert property (
    acc && is_x && !illegal && !smem[0] && (dst[3] || !STATUS_WORD_TWO[dst[2:0]])
    |=> PTR_WR_DATA == $past(k23) && PTR_WR_SEL == $past(dst))
    else $error("extended load value wrong");
  a_xload_modify: assert property (
    acc && is_x && smem[0] && mode == alm_pkg::AM_POST_INC |=> ILLEGAL_PKT && !PTR_WR_VALID)
    else $error("extended load with post-modify taken");
  a_k8_sign_ext: assert property (
    acc && is_k8 && !illegal |=> MEM_REQ && MEM_WE
    && MEM_WDATA == {{8{$past(PKT_BYTES[31])}}, $past(PKT_BYTES[31:24])})
    else $error("8-bit constant not sign-extended");
  a_k16_store: assert property (
    acc && is_k16 && !illegal |=> MEM_WE && MEM_WDATA == $past(PKT_BYTES[31:16]) ##0 MEM_REQ [*1])
    else $error("16-bit store data wrong");
  a_lock_alone: assert property (
    acc && is_lock && (!is_rmw || PAR_EXTRA) |=> ILLEGAL_PKT && !MEM_REQ)
    else $error("misplaced lock accepted");
  a_mmap_base: assert property (
    acc && is_mmap && !illegal |=> MEM_ADDR == {16'h0000, $past(smem[7:1])})
    else $error("mapped access not at page zero");
  a_scratch_block: assert property (
    acc && is_mmap && !smem[0] && smem[7:1] > alm_pkg::MMR_LAST |=> ILLEGAL_PKT)
    else $error("scratch-pad reached through map");
  a_mmap_parallel: assert property (
    acc && is_mmap && PAR_EXTRA |=> ILLEGAL_PKT && !MEM_REQ)
    else $error("map qualifier with parallel instruction");
  a_mar_no_mem: assert property (
    acc && is_mar && !illegal |=> !MEM_REQ && PKT_DONE && $stable(s_ff.dp))
    else $error("pointer modify issued memory access");
endmodule : alm_decoder
`default_nettype wire

//--- dv/alm_mem_model.sv
// Data memory model: sixteen words with an adjustable accept delay
// Assumes one request at a time, held until it is accepted
`timescale 1ns/1ps
`default_nettype none
module alm_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic we,
  input wire logic [22:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] lat,
  output logic accept,
  output var logic rvalid,
  output var logic [15:0] rdata
);
  logic [15:0] mem [16]; // Word store, low address bits only
  logic [1:0] cnt; // Wait cycles spent on the held request
  // Take the request once the chosen delay has passed
  assign accept = req && (cnt == lat);
  // Storage, read return one cycle after accept, wait count
  always @(posedge clk) begin
    rvalid <= accept && !we;
    rdata <= (accept && !we) ? mem[addr[3:0]] : ~rdata; // Stale data never held
    cnt <= (req && !accept) ? cnt + 2'h1 : 2'h0;
    if (rst) begin
      rdata <= 16'h0000;
      for (int i = 0; i < 16; i++) mem[i] <= 16'hA5C3 ^ 16'(i);
    end else if (accept && we) begin
      mem[addr[3:0]] <= wdata;
    end
  end
endmodule : alm_mem_model
`default_nettype wire

//--- dv/addr_load_lock_mmap_instrs_tb.sv
// Testbench of the decoder: loads, modify, stores, locked RMW, refusals
// Assumes the memory model on the far side and a 50 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module addr_load_lock_mmap_instrs_tb;
  logic clk, rst, pv, pr, pe, cd, lg, srm, req, we, lock, acc, rv, stall;
  logic pwv, tf1, tf2, ill, done, lk;
  logic [47:0] pb; // Packet bytes
  logic [1:0] ql, lat; // Qualifier length, memory delay
  logic [15:0] qb, st2, s1, s2, ofs, wd, rd, wdat;
  logic [22:0] addr, pwd, waddr;
  logic [3:0] psel;
  int n_compared, bad_count, nreq, cyc, n0;
  alm_decoder alm_decoder_inst (.CORE_CLK(clk), .RESET(rst), .PKT_VALID(pv), .PKT_READY(pr),
    .PKT_BYTES(pb), .QUAL_LEN(ql), .QUAL_BYTES(qb), .PAR_EXTRA(pe), .COND_D_EXEC(cd),
    .STATUS_WORD_TWO(st2), .LEGACY_COMPAT_MODE(lg), .CIRC_SIZE_REG_FIRST(s1),
    .CIRC_SIZE_REG_SECOND(s2), .OFFSET_REG(ofs), .STACK_REL_MODE(srm), .MEM_REQ(req),
    .MEM_WE(we), .MEM_ADDR(addr), .MEM_WDATA(wd), .MEM_LOCK(lock), .MEM_ACCEPT(acc),
    .MEM_RVALID(rv), .MEM_RDATA(rd), .OTHER_REQ_STALL(stall), .PTR_WR_VALID(pwv),
    .PTR_WR_SEL(psel), .PTR_WR_DATA(pwd), .TEST_FLAG_ONE(tf1), .TEST_FLAG_TWO(tf2),
    .ILLEGAL_PKT(ill), .PKT_DONE(done));
  alm_mem_model alm_mem_model_inst (.clk(clk), .rst(rst), .req(req), .we(we), .addr(addr),
    .wdata(wd), .lat(lat), .accept(acc), .rvalid(rv), .rdata(rd));
  // Clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Accepted requests, last write, locked read seen; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (req && acc) begin
      nreq <= nreq + 1;
      if (we) begin
        waddr <= addr;
        wdat <= wd;
      end else if (lock) begin
        lk <= 1'b1;
      end
    end
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Offer one packet, wait for done or refusal
  task automatic run(input logic [47:0] b, input logic [1:0] l, input logic [15:0] q, input logic x);
    @(posedge clk);
    pv <= 1'b1;
    pb <= b;
    ql <= l;
    qb <= q;
    pe <= x;
    n0 = nreq;
    @(posedge clk);
    pv <= 1'b0;
    for (int k = 0; k < 30; k++) begin
      #1;
      if (done === 1'b1 || ill === 1'b1) break;
      @(posedge clk);
    end
  endtask : run
  // Extended loads, plain and with register offset
  task automatic t_xload();
    run({alm_pkg::OP_XLOAD, 40'h00_7F_FF_FF_30}, 2'h0, 16'h0000, 1'b0);
    chk("xload sel", 32'h3, 32'(psel));
    chk("xload data", 32'h7FFFFF, 32'(pwd));
    chk("xload nreq", 32'(n0), 32'(nreq));
    run({alm_pkg::OP_XLOAD, 40'h0B_00_10_00_A0}, 2'h0, 16'h0000, 1'b0);
    chk("xload dp", 32'h1020, 32'(pwd));
    chk("xload done", 32'h1, 32'(done));
    $display("test xload finished");
  endtask : t_xload
  // Pointer modify, no memory access
  task automatic t_mar();
    run({alm_pkg::OP_MAR, 8'h43, 32'h0}, 2'h0, 16'h0000, 1'b0);
    chk("mar valid", 32'h1, 32'(pwv));
    chk("mar data", 32'h1, 32'(pwd));
    chk("mar sel", 32'h2, 32'(psel));
    chk("mar nreq", 32'(n0), 32'(nreq));
    $display("test mar finished");
  endtask : t_mar
  // Immediate stores, mapped and page relative
  task automatic t_store();
    run({alm_pkg::OP_ST_K8, 16'h20_F8, 24'h0}, 2'h1, 16'(alm_pkg::QUAL_MMAP), 1'b0);
    chk("k8 addr", 32'h10, 32'(waddr));
    chk("k8 data", 32'hFFF8, 32'(wdat));
    run({alm_pkg::OP_ST_K16, 24'h20_12_34, 16'h0}, 2'h0, 16'h0000, 1'b0);
    chk("k16 addr", 32'h1030, 32'(waddr));
    chk("k16 data", 32'h1234, 32'(wdat));
    $display("test store finished");
  endtask : t_store
  // Locked word and bit operations, then an unlocked bit clear, with a slow memory
  task automatic t_lock();
    lat <= 2'h2;
    run({8'hD9, 24'h41_0F_0F, 16'h0}, 2'h2, alm_pkg::QUAL_LOCK, 1'b0);
    chk("lock seen", 32'h1, 32'(lk));
    chk("and data", 32'h0502, 32'(wdat));
    chk("and nreq", 32'(n0 + 2), 32'(nreq));
    chk("and done", 32'h1, 32'(done));
    chk("stall off", 32'h0, 32'(stall));
    run({8'hD0, 16'h41_01, 24'h0}, 2'h2, alm_pkg::QUAL_LOCK, 1'b0);
    chk("tset flag", 32'h1, 32'(tf1));
    chk("tset data", 32'h0502, 32'(wdat));
    // Same memory word, unlocked clear into flag two
    run({8'hD3, 16'h41_01, 24'h0}, 2'h0, 16'h0000, 1'b0);
    chk("tclr flag", 32'h1, 32'(tf2));
    chk("tclr data", 32'h0500, 32'(wdat));
    chk("tclr nreq", 32'(n0 + 2), 32'(nreq));
    chk("ready", 32'h1, 32'(pr));
    $display("test lock finished");
  endtask : t_lock
  // Refused pairings leave memory untouched
  task automatic t_bad();
    logic [47:0] b [7] = '{48'hEC01_7FFF_FF30, 48'hD941_0F0F_0000, 48'hB443_0000_0000, 48'hD941_0F0F_0000,
      48'hEC03_0000_0130, 48'hE620_F800_0000, 48'hE6C0_F800_0000};
    logic [15:0] q [7] = '{16'h45F2, 16'h45F2, 16'h0098, 16'h45F2, 16'h0000, 16'h0098, 16'h0098};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      cd <= (i == 3);
      run(b[i], (q[i] == 16'h0) ? 2'h0 : (q[i] == 16'h0098) ? 2'h1 : 2'h2, q[i], i == 1 || i == 5);
      chk("refused", 32'h1, 32'(ill));
      chk("refused nreq", 32'(n0), 32'(nreq));
    end
    @(posedge clk);
    cd <= 1'b0;
    $display("test refusals finished");
  endtask : t_bad
  // Circular pointer modify and extended load, legacy sizing
  task automatic t_circ();
    @(posedge clk);
    st2 <= 16'h0024;
    lg <= 1'b1;
    s1 <= 16'h0004;
    s2 <= 16'h0010;
    run({alm_pkg::OP_MAR, 8'hA5, 32'h0}, 2'h0, 16'h0000, 1'b0);
    chk("circ mar", 32'h3, 32'(pwd));
    run({alm_pkg::OP_XLOAD, 40'h00_00_00_06_20}, 2'h0, 16'h0000, 1'b0);
    chk("circ xload", 32'h2, 32'(pwd));
    $display("test circ finished");
  endtask : t_circ
  // Verdict and end of run
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    {rst, pv, pe, cd, lg, srm, lk, ql, lat, pb, qb} = '0;
    {st2, s1, s2, ofs, nreq, cyc, n_compared, bad_count} = '0;
    rst = 1'b1;
    ofs = 16'h0020;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_xload();
    t_mar();
    t_store();
    t_lock();
    t_bad();
    t_circ();
    end_sim();
  end
endmodule : addr_load_lock_mmap_instrs_tb
`default_nettype wire
